/* File: shared/ebt_pkg.sv */
// constants shared by the eight-bit timer: register indexes, field positions,
// reset values and prescaler ratios.
// assumes an APB slave with 32-bit data, one register per aligned word.
package ebt_pkg;
  // register indexes; byte address is four times the index
  localparam logic [9:0] IDX_CR2 = 10'h051;
  localparam logic [9:0] IDX_CR1 = 10'h052;
  localparam logic [9:0] IDX_CSR = 10'h053;
  localparam logic [9:0] IDX_ICR1 = 10'h055;
  localparam logic [9:0] IDX_OCR1 = 10'h057;
  localparam logic [9:0] IDX_CTR = 10'h059;
  localparam logic [9:0] IDX_ALTERNATE_COUNT_VIEW = 10'h05B;
  localparam logic [9:0] IDX_ICR2 = 10'h05D;
  localparam logic [9:0] IDX_OCR2 = 10'h05F;
  // control_reg_one fields
  localparam int CR1_ICIE = 7;
  localparam int CR1_OCIE = 6;
  localparam int CR1_OVERFLOW_IRQ_ENABLE = 5;
  localparam int CR1_FOLV2 = 4;
  localparam int CR1_FOLV1 = 3;
  localparam int CR1_OLVL2 = 2;
  localparam int CR1_IEDG1 = 1;
  localparam int CR1_OLVL1 = 0;
  // control_reg_two fields
  localparam int CR2_OC1E = 7;
  localparam int CR2_OC2E = 6;
  localparam int CR2_CC_LSB = 2;
  localparam int CR2_IEDG2 = 1;
  // timer_status_reg: flags occupy bits 7:3, disable bit 2
  localparam int CSR_FLAG_LSB = 3;
  localparam int CSR_TIMD = 2;
  // position inside the five-bit flag vector
  localparam int FL_ICF1 = 4;
  localparam int FL_OCF1 = 3;
  localparam int FL_TOF = 2;
  localparam int FL_ICF2 = 1;
  localparam int FL_OCF2 = 0;
  // reset values
  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'hFC;
  localparam logic [7:0] OCR_RESET = 8'h00;
  localparam logic [7:0] ICR_RESET = 8'h00;
  // clock_select_field codes
  localparam logic [1:0] CC_DIV4 = 2'h0;
  localparam logic [1:0] CC_DIV2 = 2'h1;
  localparam logic [1:0] CC_DIV8 = 2'h2;
  localparam logic [1:0] CC_OSC = 2'h3;
  // prescaler ratios
  localparam logic [2:0] DIV_CPU2 = 3'h2;
  localparam logic [2:0] DIV_CPU4 = 3'h4;
  localparam logic [2:0] DIV_CPU8 = 3'h0;
  localparam int unsigned DIV_OSC = 8000;
endpackage : ebt_pkg

/* File: design/ebt_sync.sv */
// three-stage synchroniser for pins from outside the pclk domain.
// assumes asynchronous pins; output follows once stages two and three agree.
`timescale 1ns/10ps
module ebt_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q; // stage one feeds only stage two
  logic [W-1:0] lvl_d;

  // accept a new level only when the two later stages agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // registers only; pins idle high so all stages reset to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      lvl_q <= '1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule : ebt_sync

/* File: design/ebt_presc.sv */
// prescaler: one-cycle tick at the selected timer clock rate.
// assumes osc_edge is a one-cycle pulse per rising edge of half_osc_clock.
`timescale 1ns/10ps
module ebt_presc #(
  parameter int unsigned OSC_DIV = ebt_pkg::DIV_OSC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  input wire logic run,
  input wire logic [1:0] sel,
  input wire logic osc_edge,
  output logic tick
);
  localparam int OW = $clog2(OSC_DIV);
  logic [2:0] cpu_q, cpu_d; // cpu_clock divider
  logic [OW-1:0] osc_q, osc_d; // oscillator edge divider
  logic [2:0] lim;
  logic cpu_tick, osc_tick;

  if (OSC_DIV < 2) begin : g_bad_div
    $error("ebt_presc: OSC_DIV must be at least 2");
  end

  // selected ratio minus one; divide-by-8 wraps the 3-bit counter
  always_comb begin
    case (sel)
      ebt_pkg::CC_DIV2: lim = ebt_pkg::DIV_CPU2 - 3'h1;
      ebt_pkg::CC_DIV8: lim = ebt_pkg::DIV_CPU8 - 3'h1;
      default: lim = ebt_pkg::DIV_CPU4 - 3'h1;
    endcase
  end

  assign cpu_tick = run && (sel != ebt_pkg::CC_OSC) && (cpu_q >= lim);
  assign osc_tick = run && (sel == ebt_pkg::CC_OSC) && osc_edge
                    && (osc_q == OW'(OSC_DIV - 1));
  assign tick = cpu_tick || osc_tick;

  // next divider counts; frozen while not running, cleared on counter reload
  always_comb begin
    cpu_d = cpu_q;
    osc_d = osc_q;
    if (clr) begin
      cpu_d = 3'h0;
      osc_d = '0;
    end else if (run) begin
      cpu_d = cpu_tick ? 3'h0 : cpu_q + 3'h1;
      if (osc_edge) begin
        osc_d = osc_tick ? '0 : osc_q + OW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_q <= 3'h0;
      osc_q <= '0;
    end else begin
      cpu_q <= cpu_d;
      osc_q <= osc_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // divide-by-2: ticks come every second cycle while nothing else changes
  property p_div2_spacing;
    (tick && sel == ebt_pkg::CC_DIV2 && run && !clr) ##1 (run && !clr && $stable(sel))
      |-> !tick ##1 (tick || !run || clr || !$stable(sel));
  endproperty
  a_div2_spacing: assert property (p_div2_spacing) else $error("divide-by-2 spacing wrong");
endmodule : ebt_presc

/* File: design/ebt_timer.sv */
// eight-bit timer: APB registers, prescaled free-running counter, overflow,
// two captures and two compares, with low-power and reset behaviour.
// assumes an APB master on pclk and a core that supplies its interrupt mask.
`timescale 1ns/10ps
module ebt_timer #(
  parameter int unsigned OSC_DIV = ebt_pkg::DIV_OSC, // half_osc_clock ratio
  parameter bit CAP1_BONDED = 1'b1, // capture_input_one reaches a pin
  parameter bit CAP2_BONDED = 1'b1 // capture_input_two reaches a pin
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_reset,
  input wire logic halt_mode,
  input wire logic cpu_irq_mask,
  input wire logic half_osc_clock,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  output logic compare_output_one,
  output logic compare_output_two,
  output logic compare_output_one_en,
  output logic compare_output_two_en,
  output logic timer_irq
);
  // state
  logic [7:0] cr1_q, cr1_d; // control_reg_one
  logic [7:0] cr2_q, cr2_d; // control_reg_two
  logic timd_q, timd_d; // timer disable
  logic [7:0] cnt_q, cnt_d; // free-running count
  logic [7:0] icr1_q, icr1_d, icr2_q, icr2_d; // capture values
  logic [7:0] ocr1_q, ocr1_d, ocr2_q, ocr2_d; // compare values
  logic [4:0] flags_q, flags_d; // status flags
  logic [4:0] arm_q, arm_d; // flags seen by a status read
  logic oc1_q, oc1_d, oc2_q, oc2_d; // compare pin latches
  logic [1:0] cap_prev_q, cap_prev_d; // previous synced capture levels
  logic osc_prev_q, osc_prev_d; // previous synced oscillator level
  logic [31:0] rdata_q, rdata_d;

  // combinational
  logic [2:0] pin_lvl;
  logic [1:0] cap_lvl, cap_edge;
  logic run, tick, setup, access, mapped, reload, ovf;
  logic [4:0] ev, clr;

  // decode one register index from the byte address
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return (a[1:0] == 2'h0) && (a[11:2] == idx);
  endfunction

  // edge selected by an edge bit: one picks rising, zero falling
  function automatic logic pick_edge(input logic now, input logic was, input logic rise);
    return rise ? (now && !was) : (!now && was);
  endfunction

  if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad_div
    $error("ebt_timer: OSC_DIV out of range");
  end

  // all pins cross into pclk through three stages
  ebt_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin({half_osc_clock, capture_input_two, capture_input_one}),
    .level(pin_lvl)
  );

  // an unbonded input reads as constant one
  assign cap_lvl[0] = CAP1_BONDED ? pin_lvl[0] : 1'b1;
  assign cap_lvl[1] = CAP2_BONDED ? pin_lvl[1] : 1'b1;

  // halt freezes prescaler and count; wait mode has no input because it changes nothing
  assign run = !timd_q && !halt_mode && !internal_reset;

  ebt_presc #(.OSC_DIV(OSC_DIV)) u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .clr(reload || internal_reset),
    .run(run),
    .sel(cr2_q[ebt_pkg::CR2_CC_LSB +: 2]),
    .osc_edge(pin_lvl[2] && !osc_prev_q),
    .tick(tick)
  );

  // bus phases and decode
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1; // every access completes in its first access cycle
  assign mapped = hit(paddr, ebt_pkg::IDX_CR2) || hit(paddr, ebt_pkg::IDX_CR1)
                  || hit(paddr, ebt_pkg::IDX_CSR) || hit(paddr, ebt_pkg::IDX_ICR1)
                  || hit(paddr, ebt_pkg::IDX_OCR1) || hit(paddr, ebt_pkg::IDX_CTR)
                  || hit(paddr, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW) || hit(paddr, ebt_pkg::IDX_ICR2)
                  || hit(paddr, ebt_pkg::IDX_OCR2);
  assign pslverr = access && !mapped;
  assign prdata = rdata_q;

  // a write to either view reloads the count
  assign reload = access && pwrite && (hit(paddr, ebt_pkg::IDX_CTR) || hit(paddr, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW));
  assign ovf = tick && !reload && (cnt_q == 8'hFF);

  // capture edges, each with its own edge bit
  assign cap_edge[0] = pick_edge(cap_lvl[0], cap_prev_q[0], cr1_q[ebt_pkg::CR1_IEDG1]);
  assign cap_edge[1] = pick_edge(cap_lvl[1], cap_prev_q[1], cr2_q[ebt_pkg::CR2_IEDG2]);

  // hardware events into the flag vector
  always_comb begin
    ev = 5'h00;
    ev[ebt_pkg::FL_TOF] = ovf;
    ev[ebt_pkg::FL_ICF1] = cap_edge[0];
    ev[ebt_pkg::FL_ICF2] = cap_edge[1];
    ev[ebt_pkg::FL_OCF1] = tick && (cnt_q == ocr1_q) && !cr1_q[ebt_pkg::CR1_FOLV1];
    ev[ebt_pkg::FL_OCF2] = tick && (cnt_q == ocr2_q) && !cr1_q[ebt_pkg::CR1_FOLV2];
  end

  // second step of the clear: access to the owning register of an armed flag
  always_comb begin
    clr = 5'h00;
    if (access) begin
      clr[ebt_pkg::FL_TOF] = hit(paddr, ebt_pkg::IDX_CTR);
      clr[ebt_pkg::FL_ICF1] = hit(paddr, ebt_pkg::IDX_ICR1);
      clr[ebt_pkg::FL_ICF2] = hit(paddr, ebt_pkg::IDX_ICR2);
      clr[ebt_pkg::FL_OCF1] = hit(paddr, ebt_pkg::IDX_OCR1);
      clr[ebt_pkg::FL_OCF2] = hit(paddr, ebt_pkg::IDX_OCR2);
    end
    clr = clr & arm_q;
  end

  // read data is latched in the setup cycle so the access cycle can answer at once
  always_comb begin
    rdata_d = rdata_q;
    if (setup && !pwrite) begin
      rdata_d = 32'h0000_0000;
      if (hit(paddr, ebt_pkg::IDX_CR2)) begin
        rdata_d[7:0] = cr2_q;
      end else if (hit(paddr, ebt_pkg::IDX_CR1)) begin
        rdata_d[7:0] = cr1_q;
      end else if (hit(paddr, ebt_pkg::IDX_CSR)) begin
        rdata_d[7:0] = {flags_q, timd_q, 2'b00};
      end else if (hit(paddr, ebt_pkg::IDX_ICR1)) begin
        rdata_d[7:0] = icr1_q;
      end else if (hit(paddr, ebt_pkg::IDX_OCR1)) begin
        rdata_d[7:0] = ocr1_q;
      end else if (hit(paddr, ebt_pkg::IDX_CTR) || hit(paddr, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW)) begin
        rdata_d[7:0] = cnt_q; // both views show the same count
      end else if (hit(paddr, ebt_pkg::IDX_ICR2)) begin
        rdata_d[7:0] = icr2_q;
      end else if (hit(paddr, ebt_pkg::IDX_OCR2)) begin
        rdata_d[7:0] = ocr2_q;
      end
    end
  end

  // next state of registers, counter, flags and pin latches
  always_comb begin
    cr1_d = cr1_q;
    cr2_d = cr2_q;
    timd_d = timd_q;
    ocr1_d = ocr1_q;
    ocr2_d = ocr2_q;
    icr1_d = cap_edge[0] ? cnt_q : icr1_q;
    icr2_d = cap_edge[1] ? cnt_q : icr2_q;
    cap_prev_d = cap_lvl;
    osc_prev_d = pin_lvl[2];
    // set wins over clear when both land together
    flags_d = (flags_q & ~clr) | ev;
    // a status read arms the flags that are set at that moment
    arm_d = arm_q & ~clr;
    if (access && !pwrite && hit(paddr, ebt_pkg::IDX_CSR)) begin
      arm_d = arm_d | flags_q;
    end
    // count: reload beats increment
    cnt_d = cnt_q;
    if (reload) begin
      cnt_d = ebt_pkg::CNT_RESET;
    end else if (tick) begin
      cnt_d = cnt_q + 8'h01;
    end
    // compare pins take the level on match, or follow it while forced
    oc1_d = oc1_q;
    oc2_d = oc2_q;
    if (cr1_q[ebt_pkg::CR1_FOLV1] || ev[ebt_pkg::FL_OCF1]) begin
      oc1_d = cr1_q[ebt_pkg::CR1_OLVL1];
    end
    if (cr1_q[ebt_pkg::CR1_FOLV2] || ev[ebt_pkg::FL_OCF2]) begin
      oc2_d = cr1_q[ebt_pkg::CR1_OLVL2];
    end
    // register writes; status flags and capture values are read-only
    if (access && pwrite) begin
      if (hit(paddr, ebt_pkg::IDX_CR2)) begin
        cr2_d = pwdata[7:0];
      end else if (hit(paddr, ebt_pkg::IDX_CR1)) begin
        cr1_d = pwdata[7:0];
      end else if (hit(paddr, ebt_pkg::IDX_CSR)) begin
        timd_d = pwdata[ebt_pkg::CSR_TIMD];
      end else if (hit(paddr, ebt_pkg::IDX_OCR1)) begin
        ocr1_d = pwdata[7:0];
      end else if (hit(paddr, ebt_pkg::IDX_OCR2)) begin
        ocr2_d = pwdata[7:0];
      end
    end
    // internal reset holds registers, count, captures, flags and pin latches at reset; edge history and read data still update
    if (internal_reset) begin
      cr1_d = ebt_pkg::CR_RESET;
      cr2_d = ebt_pkg::CR_RESET;
      timd_d = 1'b0;
      cnt_d = ebt_pkg::CNT_RESET;
      ocr1_d = ebt_pkg::OCR_RESET;
      ocr2_d = ebt_pkg::OCR_RESET;
      icr1_d = ebt_pkg::ICR_RESET;
      icr2_d = ebt_pkg::ICR_RESET;
      flags_d = 5'h00;
      arm_d = 5'h00;
      oc1_d = 1'b0;
      oc2_d = 1'b0;
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr1_q <= ebt_pkg::CR_RESET;
      cr2_q <= ebt_pkg::CR_RESET;
      timd_q <= 1'b0;
      cnt_q <= ebt_pkg::CNT_RESET;
      icr1_q <= ebt_pkg::ICR_RESET;
      icr2_q <= ebt_pkg::ICR_RESET;
      ocr1_q <= ebt_pkg::OCR_RESET;
      ocr2_q <= ebt_pkg::OCR_RESET;
      flags_q <= 5'h00;
      arm_q <= 5'h00;
      oc1_q <= 1'b0;
      oc2_q <= 1'b0;
      cap_prev_q <= 2'h3;
      osc_prev_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      cr1_q <= cr1_d;
      cr2_q <= cr2_d;
      timd_q <= timd_d;
      cnt_q <= cnt_d;
      icr1_q <= icr1_d;
      icr2_q <= icr2_d;
      ocr1_q <= ocr1_d;
      ocr2_q <= ocr2_d;
      flags_q <= flags_d;
      arm_q <= arm_d;
      oc1_q <= oc1_d;
      oc2_q <= oc2_d;
      cap_prev_q <= cap_prev_d;
      osc_prev_q <= osc_prev_d;
      rdata_q <= rdata_d;
    end
  end

  // pins are released while disabled so they stop drawing power
  assign compare_output_one = oc1_q;
  assign compare_output_two = oc2_q;
  assign compare_output_one_en = cr2_q[ebt_pkg::CR2_OC1E] && !timd_q;
  assign compare_output_two_en = cr2_q[ebt_pkg::CR2_OC2E] && !timd_q;

  // one shared request, held off by the core's mask and left pending
  assign timer_irq = !cpu_irq_mask && (
      (flags_q[ebt_pkg::FL_TOF] && cr1_q[ebt_pkg::CR1_OVERFLOW_IRQ_ENABLE])
      || ((flags_q[ebt_pkg::FL_ICF1] || flags_q[ebt_pkg::FL_ICF2]) && cr1_q[ebt_pkg::CR1_ICIE])
      || ((flags_q[ebt_pkg::FL_OCF1] || flags_q[ebt_pkg::FL_OCF2]) && cr1_q[ebt_pkg::CR1_OCIE]));

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_view_write;
    access && pwrite && !internal_reset && (hit(paddr, ebt_pkg::IDX_CTR) || hit(paddr, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW));
  endsequence
  sequence s_main_clear;
    access && hit(paddr, ebt_pkg::IDX_CTR) && arm_q[ebt_pkg::FL_TOF] && !ovf && !internal_reset;
  endsequence

  property p_view_reload;
    s_view_write |=> cnt_q == 8'hFC;
  endproperty
  a_view_reload: assert property (p_view_reload) else $error("view write did not reload");
  property p_overflow_set;
    (tick && cnt_q == 8'hFF && !reload && !internal_reset) |=> flags_q[ebt_pkg::FL_TOF] && cnt_q == 8'h00;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("rollover missed overflow");
  property p_tof_clear;
    s_main_clear |=> !flags_q[ebt_pkg::FL_TOF];
  endproperty
  a_tof_clear: assert property (p_tof_clear) else $error("main view access did not clear");
  property p_alt_keeps;
    (access && hit(paddr, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW) && flags_q[ebt_pkg::FL_TOF] && !internal_reset)
      |=> flags_q[ebt_pkg::FL_TOF];
  endproperty
  a_alt_keeps: assert property (p_alt_keeps) else $error("alternate view cleared overflow");
  property p_halt_hold;
    (halt_mode && !reload && !internal_reset) |=> $stable(cnt_q);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("count moved in halt");
  property p_irq_gate;
    (flags_q[ebt_pkg::FL_TOF] && cr1_q[ebt_pkg::CR1_OVERFLOW_IRQ_ENABLE]) |-> timer_irq == !cpu_irq_mask;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("overflow request gating wrong");
  property p_step_one;
    (tick && !reload && !internal_reset) |=> cnt_q == $past(cnt_q) + 8'h01;
  endproperty
  a_step_one: assert property (p_step_one) else $error("count did not step by one");
  property p_int_reset;
    internal_reset |=> cnt_q == 8'hFC && flags_q == 5'h00 && !timer_irq;
  endproperty
  a_int_reset: assert property (p_int_reset) else $error("internal reset not held");
  property p_capture;
    (cap_edge[0] && !internal_reset) |=> flags_q[ebt_pkg::FL_ICF1] && icr1_q == $past(cnt_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture one lost");
endmodule : ebt_timer

/* File: bench/ebt_far_side.sv */
// far-side model: oscillator pin and the two capture pins of the timer.
// assumes pclk from the bench; capture pins idle high as with a pull-up.
`timescale 1ns/10ps
module ebt_far_side (
  input wire logic pclk,
  input wire logic osc_on,
  input wire logic [1:0] cap_req,
  output logic half_osc_clock,
  output logic capture_input_one,
  output logic capture_input_two
);
  logic [1:0] ph_q = 2'h0; // oscillator phase
  logic [3:0] low_q = 4'h0; // cycles left in a capture pulse
  logic [1:0] sel_q = 2'h0; // which pin pulses
  initial half_osc_clock = 1'b0;
  // locked to pclk, period six cycles, so the bench can predict counts exactly
  always @(posedge pclk) begin
    if (osc_on) begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (ph_q == 2'h2) begin
        half_osc_clock <= ~half_osc_clock;
      end
    end
  end
  // a request gives an eight-cycle low pulse: a fall, then a rise
  always @(posedge pclk) begin
    if (cap_req != 2'h0) begin
      low_q <= 4'h8;
      sel_q <= cap_req;
    end else if (low_q != 4'h0) begin
      low_q <= low_q - 4'h1;
    end
  end
  assign capture_input_one = !(low_q != 4'h0 && sel_q[0]);
  assign capture_input_two = !(low_q != 4'h0 && sel_q[1]);
endmodule : ebt_far_side

/* File: bench/tb_eight_bit_timer_counter.sv */
// self-checking bench for the eight-bit timer over apb.
// assumes ebt_pkg compiled first; oscillator ratio shortened to four.
`timescale 1ns/10ps
module tb_eight_bit_timer_counter;
  localparam int OSC_DIV = 4; // short ratio keeps the run brief
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic internal_reset = 1'b0, halt_mode = 1'b0, cpu_irq_mask = 1'b1;
  logic osc_on = 1'b1;
  logic [1:0] cap_req = 2'h0;
  logic half_osc_clock, cap1, cap2, cmp1, cmp2, en1, en2, timer_irq;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hf68b_4b1f;
  logic [7:0] v, a, b;
  logic e;
  int k;
  logic [1:0] cc_t [4] = '{ebt_pkg::CC_DIV2, ebt_pkg::CC_DIV4, ebt_pkg::CC_DIV8, ebt_pkg::CC_OSC};
  int dv [4] = '{2, 4, 8, OSC_DIV * 6}; // pclk cycles per count
  always #2.5 pclk = ~pclk;
  ebt_timer #(.OSC_DIV(OSC_DIV)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_reset(internal_reset), .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask),
    .half_osc_clock(half_osc_clock), .capture_input_one(cap1), .capture_input_two(cap2),
    .compare_output_one(cmp1), .compare_output_two(cmp2), .compare_output_one_en(en1),
    .compare_output_two_en(en2), .timer_irq(timer_irq));
  ebt_far_side far_u (.pclk(pclk), .osc_on(osc_on), .cap_req(cap_req), .half_osc_clock(half_osc_clock),
    .capture_input_one(cap1), .capture_input_two(cap2));
  // galois-free shift register, fixed seed keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // count expected k timer clocks later
  function automatic logic [7:0] adv(input logic [7:0] c, input int n);
    return c + n[7:0];
  endfunction : adv
  // one apb transfer; data and error taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer however long it takes; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    check_count++;
    if (got !== ex) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  // hang guard: far above the longest expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // freeze the count so reload and capture values are exact
    apb(1'b1, ebt_pkg::IDX_CSR, 8'h04, v, e);
    apb(1'b1, ebt_pkg::IDX_CTR, 8'h37, v, e);
    apb(1'b0, ebt_pkg::IDX_CTR, 8'h00, v, e);
    chk("main view", 8'hfc, v);
    apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, v, e);
    chk("alt view", 8'hfc, v);
    apb(1'b0, ebt_pkg::IDX_CR2, 8'h00, v, e);
    chk("ctl two", ebt_pkg::CR_RESET, v);
    apb(1'b0, 10'h058, 8'h00, v, e);
    chk("unmapped err", 8'h01, {7'h00, e});
    chk("unmapped data", 8'h00, v);
    // falling-edge captures on both pins while frozen
    cap_req <= 2'b01;
    @(posedge pclk) cap_req <= 2'b00;
    repeat (20) @(posedge pclk);
    apb(1'b0, ebt_pkg::IDX_CSR, 8'h00, v, e);
    chk("status cap1", 8'h84, v);
    apb(1'b0, ebt_pkg::IDX_ICR1, 8'h00, v, e);
    chk("capture one", 8'hfc, v);
    cap_req <= 2'b10;
    @(posedge pclk) cap_req <= 2'b00;
    repeat (20) @(posedge pclk);
    apb(1'b0, ebt_pkg::IDX_CSR, 8'h00, v, e);
    chk("status cap2", 8'h14, v);
    apb(1'b0, ebt_pkg::IDX_ICR2, 8'h00, v, e);
    chk("capture two", 8'hfc, v);
    seed = lfsr(seed);
    apb(1'b1, ebt_pkg::IDX_OCR2, seed[7:0], v, e);
    apb(1'b0, ebt_pkg::IDX_OCR2, 8'h00, v, e);
    chk("compare two", seed[7:0], v);
    apb(1'b1, ebt_pkg::IDX_CSR, 8'h00, v, e);
    // every rate: a random gap and a full period, both at the same phase
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ebt_pkg::IDX_CR2, {4'h0, cc_t[i], 2'b00}, v, e);
      for (int j = 0; j < 2; j++) begin
        seed = lfsr(seed);
        k = (j == 0) ? 1 + int'(seed[7:0] % 8'd255) : 256;
        apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, a, e);
        repeat (dv[i] * k - 3) @(posedge pclk);
        apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, b, e);
        chk("count rate", adv(a, k), b);
      end
    end
    // overflow flag and its two-step clear, with the core mask
    apb(1'b1, ebt_pkg::IDX_CR1, 8'h20, v, e);
    apb(1'b1, ebt_pkg::IDX_CR2, {4'h0, ebt_pkg::CC_DIV8, 2'b00}, v, e);
    apb(1'b0, ebt_pkg::IDX_CSR, 8'h00, v, e);
    apb(1'b1, ebt_pkg::IDX_CTR, 8'h00, v, e);
    apb(1'b0, ebt_pkg::IDX_CSR, 8'h00, v, e);
    chk("flag cleared", 8'h00, {7'h00, v[5]});
    repeat (40) @(posedge pclk);
    chk("irq masked", 8'h00, {7'h00, timer_irq});
    cpu_irq_mask <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("irq on", 8'h01, {7'h00, timer_irq});
    apb(1'b0, ebt_pkg::IDX_CSR, 8'h00, v, e);
    chk("flag set", 8'h01, {7'h00, v[5]});
    apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, v, e);
    apb(1'b0, ebt_pkg::IDX_CSR, 8'h00, v, e);
    chk("alt no clear", 8'h01, {7'h00, v[5]});
    apb(1'b0, ebt_pkg::IDX_CTR, 8'h00, v, e);
    @(posedge pclk);
    chk("irq cleared", 8'h00, {7'h00, timer_irq});
    // compare one drives its pin high on match
    apb(1'b1, ebt_pkg::IDX_CR1, 8'h01, v, e);
    apb(1'b1, ebt_pkg::IDX_OCR1, 8'hfe, v, e);
    apb(1'b1, ebt_pkg::IDX_CR2, {4'h8, ebt_pkg::CC_DIV2, 2'b00}, v, e);
    apb(1'b1, ebt_pkg::IDX_CTR, 8'h00, v, e);
    chk("pin before", 8'h00, {7'h00, cmp1});
    repeat (20) @(posedge pclk);
    chk("pin match", 8'h03, {6'h00, en1, cmp1});
    apb(1'b1, ebt_pkg::IDX_CSR, 8'h04, v, e);
    @(posedge pclk);
    chk("pin off", 8'h00, {7'h00, en1});
    apb(1'b1, ebt_pkg::IDX_CSR, 8'h00, v, e);
    // halt freezes, reset while halted leaves the reload value
    halt_mode <= 1'b1;
    apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, a, e);
    repeat (100) @(posedge pclk);
    apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, b, e);
    chk("halt hold", a, b);
    internal_reset <= 1'b1;
    repeat (3) @(posedge pclk);
    internal_reset <= 1'b0;
    apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, v, e);
    chk("reset wake", 8'hfc, v);
    apb(1'b0, ebt_pkg::IDX_CR1, 8'h00, v, e);
    chk("reset ctl", 8'h00, v);
    halt_mode <= 1'b0;
    repeat (30) @(posedge pclk);
    apb(1'b0, ebt_pkg::IDX_ALTERNATE_COUNT_VIEW, 8'h00, b, e);
    chk("resumed", 8'h01, {7'h00, b != 8'hfc});
    conclude();
  end
endmodule : tb_eight_bit_timer_counter
